// ### hdl/mtc_downcnt.sv
`timescale 1ns/10ps
`default_nettype none

// 16-bit down-counter, load has priority over decrement
module mtc_downcnt (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic load,
   input wire logic [15:0] load_val,
   input wire logic dec,
   output logic [15:0] count,
   output logic uflow
);

   typedef struct packed {
      logic [15:0] cnt;
   } mtc_cnt_t;

   mtc_cnt_t s_r;
   mtc_cnt_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (load) begin
         s_nxt.cnt = load_val;
      end else if (dec) begin
         s_nxt.cnt = s_r.cnt - 16'h0001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_r.cnt <= mtc_pkg::WORD_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign count = s_r.cnt;
   assign uflow = dec & (s_r.cnt == 16'h0000);

endmodule

`default_nettype wire

// ### hdl/mtc_edge.sv
`timescale 1ns/10ps
`default_nettype none

// one-cycle rise and fall pulses from a synchronous input
module mtc_edge (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic sig,
   output logic rise,
   output logic fall
);

   typedef struct packed {
      logic prev;
      logic armed;
   } mtc_edge_t;

   mtc_edge_t s_r;
   mtc_edge_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.prev = sig;
      s_nxt.armed = 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // not armed in the first cycle after reset: avoids a false edge
   assign rise = s_r.armed & sig & ~s_r.prev;
   assign fall = s_r.armed & ~sig & s_r.prev;

endmodule

`default_nettype wire

// ### hdl/mtc_pkg.sv
package mtc_pkg;

   // ---------------------------------------------------------------
   // register map (word index on the register port)
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_COUNT = 4'h1;
   localparam logic [3:0] ADDR_RELOAD_A = 4'h2;
   localparam logic [3:0] ADDR_RELOAD_B = 4'h3;

   // ---------------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------------
   localparam int CTRL_MODE3 = 7;
   localparam int CTRL_MODE2 = 6;
   localparam int CTRL_MODE1 = 5;
   localparam int CTRL_RUN = 4;
   localparam int CTRL_PNDA = 3;
   localparam int CTRL_ENA = 2;
   localparam int CTRL_PNDB = 1;
   localparam int CTRL_ENB = 0;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [15:0] READ_IDLE = 16'h0000;

   // ---------------------------------------------------------------
   // operating modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MTC_PWM,
      MTC_EVT,
      MTC_CAP
   } mtc_mode_t;

endpackage

// ### hdl/mtc_timer.sv
`timescale 1ns/10ps
`default_nettype none

// Operation
// - event mode: pin B rise sets pending B when enable B is set
// - event mode: pin A never driven
// - capture mode: counter decrements every cycle
// - capture edges copy count to A/B
// - register reads never pause the count
// - edge polarity set by the mode code: pin A falls on x11, pin B falls on all but 010
// - capture edges set pending A/B
// - enable A/B gate interrupts, 1 enables
// - capture underflow sets run/underflow flag
// - capture underflow shares interrupt A
// - run flag starts/stops in PWM/event
// - 00x event count, underflow A, pin B
// - capture codes 010, 110, 011 (111)
// - event underflow sets pending A
// - PWM reloads A first, then B, A...
// - 16-bit down-counter, two 16-bit registers
module mtc_timer (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic timer_pin_a_i,
   output logic timer_pin_a_o,
   output logic timer_pin_a_oe,
   input wire logic timer_pin_b,
   output logic irq_a,
   output logic irq_b
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] ctrl;
      logic [15:0] reload_capture_reg_a;
      logic [15:0] reload_capture_reg_b;
      logic sel_b;
      logic pwm_out;
      logic [15:0] rdata;
   } mtc_state_t;

   mtc_state_t s_r;
   mtc_state_t s_nxt;

   mtc_pkg::mtc_mode_t mode;
   logic mode_sel_bit3;
   logic mode_sel_bit2;
   logic mode_sel_bit1;
   logic run_or_underflow_flag;
   logic pending_flag_a;
   logic pending_flag_b;
   logic irq_enable_a;
   logic irq_enable_b;
   logic rise_a;
   logic fall_a;
   logic rise_b;
   logic fall_b;
   logic edge_a_neg;
   logic edge_b_neg;
   logic cap_ev_a;
   logic cap_ev_b;
   logic cnt_wr;
   logic cnt_dec;
   logic cnt_load;
   logic [15:0] cnt_load_val;
   logic [15:0] count;
   logic cnt_uflow;
   logic uf;
   logic set_pnda;
   logic set_pndb;
   logic pwm_toggle;

   assign mode_sel_bit3 = s_r.ctrl[mtc_pkg::CTRL_MODE3];
   assign mode_sel_bit2 = s_r.ctrl[mtc_pkg::CTRL_MODE2];
   assign mode_sel_bit1 = s_r.ctrl[mtc_pkg::CTRL_MODE1];
   assign run_or_underflow_flag = s_r.ctrl[mtc_pkg::CTRL_RUN];
   assign pending_flag_a = s_r.ctrl[mtc_pkg::CTRL_PNDA];
   assign irq_enable_a = s_r.ctrl[mtc_pkg::CTRL_ENA];
   assign pending_flag_b = s_r.ctrl[mtc_pkg::CTRL_PNDB];
   assign irq_enable_b = s_r.ctrl[mtc_pkg::CTRL_ENB];

   // ---------------------------------------------------------------
   // mode decode
   // ---------------------------------------------------------------
   always_comb begin
      case ({mode_sel_bit3, mode_sel_bit2})
         2'b10: mode = mtc_pkg::MTC_PWM;
         2'b00: mode = mtc_pkg::MTC_EVT;
         2'b01, 2'b11: mode = mtc_pkg::MTC_CAP;
         default: mode = mtc_pkg::MTC_EVT;
      endcase
   end

   // 101 toggles the pin, 100 leaves it alone
   assign pwm_toggle = (mode == mtc_pkg::MTC_PWM) & mode_sel_bit1;

   // ---------------------------------------------------------------
   // pin edges
   // ---------------------------------------------------------------
   mtc_edge u_edge_a (
      .sys_clk(sys_clk),
      .reset(reset),
      .sig(timer_pin_a_i),
      .rise(rise_a),
      .fall(fall_a)
   );

   mtc_edge u_edge_b (
      .sys_clk(sys_clk),
      .reset(reset),
      .sig(timer_pin_b),
      .rise(rise_b),
      .fall(fall_b)
   );

   // pin A falls on x11, pin B falls on all but 010
   assign edge_a_neg = mode_sel_bit1;
   assign edge_b_neg = mode_sel_bit3 | mode_sel_bit1;
   assign cap_ev_a = (mode == mtc_pkg::MTC_CAP) & (edge_a_neg ? fall_a : rise_a);
   assign cap_ev_b = (mode == mtc_pkg::MTC_CAP) & (edge_b_neg ? fall_b : rise_b);

   // ---------------------------------------------------------------
   // counter
   // ---------------------------------------------------------------
   assign cnt_wr = reg_wr & (reg_addr == mtc_pkg::ADDR_COUNT);

   always_comb begin
      case (mode)
         mtc_pkg::MTC_CAP: cnt_dec = 1'b1;
         mtc_pkg::MTC_PWM: cnt_dec = run_or_underflow_flag;
         mtc_pkg::MTC_EVT: cnt_dec = run_or_underflow_flag & rise_a;
         default: cnt_dec = 1'b0;
      endcase
   end

   // a software write to the count replaces that cycle's step
   assign uf = cnt_uflow & ~cnt_wr;

   // capture mode simply wraps; the others reload on underflow
   assign cnt_load_val = (mode == mtc_pkg::MTC_PWM && s_r.sel_b) ? s_r.reload_capture_reg_b
      : s_r.reload_capture_reg_a;
   assign cnt_load = cnt_wr | (uf & (mode != mtc_pkg::MTC_CAP));

   mtc_downcnt u_cnt (
      .sys_clk(sys_clk),
      .reset(reset),
      .load(cnt_load),
      .load_val(cnt_wr ? reg_wdata : cnt_load_val),
      .dec(cnt_dec),
      .count(count),
      .uflow(cnt_uflow)
   );

   // ---------------------------------------------------------------
   // pending sources
   // ---------------------------------------------------------------
   always_comb begin
      set_pnda = 1'b0;
      set_pndb = 1'b0;
      case (mode)
         mtc_pkg::MTC_PWM: begin
            set_pnda = uf & ~s_r.sel_b;
            set_pndb = uf & s_r.sel_b;
         end
         mtc_pkg::MTC_EVT: begin
            set_pnda = uf;
            set_pndb = irq_enable_b & rise_b;
         end
         mtc_pkg::MTC_CAP: begin
            set_pnda = cap_ev_a;
            set_pndb = cap_ev_b;
         end
         default: set_pnda = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // register file and next state
   // ---------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.rdata = mtc_pkg::READ_IDLE;
      // reads have no side effects on the count
      if (reg_rd) begin
         case (reg_addr)
            mtc_pkg::ADDR_CTRL: s_nxt.rdata = {8'h00, s_r.ctrl};
            mtc_pkg::ADDR_COUNT: s_nxt.rdata = count;
            mtc_pkg::ADDR_RELOAD_A: s_nxt.rdata = s_r.reload_capture_reg_a;
            mtc_pkg::ADDR_RELOAD_B: s_nxt.rdata = s_r.reload_capture_reg_b;
            default: s_nxt.rdata = mtc_pkg::READ_IDLE;
         endcase
      end
      if (reg_wr) begin
         case (reg_addr)
            mtc_pkg::ADDR_CTRL: s_nxt.ctrl = reg_wdata[7:0];
            mtc_pkg::ADDR_RELOAD_A: s_nxt.reload_capture_reg_a = reg_wdata;
            mtc_pkg::ADDR_RELOAD_B: s_nxt.reload_capture_reg_b = reg_wdata;
            default: s_nxt.rdata = s_nxt.rdata;
         endcase
      end
      // hardware sets after the write: a set never gets lost
      if (set_pnda) begin
         s_nxt.ctrl[mtc_pkg::CTRL_PNDA] = 1'b1;
      end
      if (set_pndb) begin
         s_nxt.ctrl[mtc_pkg::CTRL_PNDB] = 1'b1;
      end
      if (mode == mtc_pkg::MTC_CAP && uf) begin
         s_nxt.ctrl[mtc_pkg::CTRL_RUN] = 1'b1;
      end
      // captures beat a same-cycle write to the holder
      if (cap_ev_a) begin
         s_nxt.reload_capture_reg_a = count;
      end
      if (cap_ev_b) begin
         s_nxt.reload_capture_reg_b = count;
      end
      // reload order restarts from A whenever PWM is stopped
      if (mode != mtc_pkg::MTC_PWM || !run_or_underflow_flag) begin
         s_nxt.sel_b = 1'b0;
      end else if (uf) begin
         s_nxt.sel_b = ~s_r.sel_b;
      end
      if (pwm_toggle && uf) begin
         s_nxt.pwm_out = ~s_r.pwm_out;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_r.ctrl <= mtc_pkg::CTRL_RST;
         s_r.reload_capture_reg_a <= mtc_pkg::WORD_RST;
         s_r.reload_capture_reg_b <= mtc_pkg::WORD_RST;
         s_r.sel_b <= 1'b0;
         s_r.pwm_out <= 1'b0;
         s_r.rdata <= mtc_pkg::READ_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign reg_rdata = s_r.rdata;
   assign timer_pin_a_o = s_r.pwm_out;
   // pin A is the count input in event mode, so never drive it there
   assign timer_pin_a_oe = pwm_toggle;
   assign irq_a = irq_enable_a & (pending_flag_a |
      ((mode == mtc_pkg::MTC_CAP) & run_or_underflow_flag));
   assign irq_b = irq_enable_b & pending_flag_b;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   a_evt_pin_quiet: assert property (
      (mode == mtc_pkg::MTC_EVT) |-> !timer_pin_a_oe)
      else $error("pin A driven in event mode");

   a_cap_count_run: assert property (
      (mode == mtc_pkg::MTC_CAP && !cnt_wr) |=> (count == $past(count) - 16'h0001))
      else $error("capture counter did not decrement");

   a_cap_load_a: assert property (
      cap_ev_a |=> (s_r.reload_capture_reg_a == $past(count)))
      else $error("capture A missed the count");

   a_cap_load_b: assert property (
      cap_ev_b |=> (s_r.reload_capture_reg_b == $past(count)) && pending_flag_b)
      else $error("capture B missed the count or flag");

   a_cap_edge_pnda: assert property (
      (mode == mtc_pkg::MTC_CAP && mode_sel_bit1 && fall_a) |=> pending_flag_a)
      else $error("falling capture edge did not set pending A");

   a_cap_uflow_flag: assert property (
      (mode == mtc_pkg::MTC_CAP && count == 16'h0000 && !cnt_wr)
      |=> run_or_underflow_flag && count == 16'hFFFF)
      else $error("capture underflow flag not set");

   a_cap_irq_share: assert property (
      (mode == mtc_pkg::MTC_CAP && run_or_underflow_flag && irq_enable_a) |-> irq_a)
      else $error("capture underflow did not raise interrupt A");

   a_ena_gate: assert property (
      !irq_enable_a |-> !irq_a)
      else $error("interrupt A without enable");

   a_stop_holds: assert property (
      (mode != mtc_pkg::MTC_CAP && !run_or_underflow_flag && !cnt_wr) |=> $stable(count))
      else $error("stopped counter moved");

   a_evt_b_edge: assert property (
      (mode == mtc_pkg::MTC_EVT && irq_enable_b && rise_b) |=> pending_flag_b)
      else $error("event-mode pin B edge lost");

   a_evt_uflow: assert property (
      (mode == mtc_pkg::MTC_EVT && uf) |=> pending_flag_a
         && count == $past(s_r.reload_capture_reg_a))
      else $error("event underflow handling wrong");

   a_pwm_first_a: assert property (
      (mode == mtc_pkg::MTC_PWM && uf && !s_r.sel_b)
      |=> count == $past(s_r.reload_capture_reg_a) && pending_flag_a)
      else $error("PWM reload from A wrong");

   a_pwm_then_b: assert property (
      (mode == mtc_pkg::MTC_PWM && uf && s_r.sel_b)
      |=> count == $past(s_r.reload_capture_reg_b) && pending_flag_b)
      else $error("PWM reload from B wrong");

   c_pwm_toggle: cover property (pwm_toggle && uf ##1 timer_pin_a_o);
   c_evt_uflow: cover property (mode == mtc_pkg::MTC_EVT && uf);
   c_cap_both: cover property (cap_ev_a ##[1:20] cap_ev_b);
   c_cap_uf_irq: cover property (mode == mtc_pkg::MTC_CAP && uf && irq_enable_a);

endmodule

`default_nettype wire

// ### verif/mtc_pins.sv
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// pin sources and pwm load
// ---------------------------------------------------------------
module mtc_pins (
   input wire logic src_a,
   input wire logic src_b,
   input wire logic pin_a_o,
   input wire logic pin_a_oe,
   output logic pin_a,
   output logic pin_b
);
   // pad level: the block wins while it drives, so a stray source cannot mask pwm
   assign pin_a = pin_a_oe ? pin_a_o : src_a;
   assign pin_b = src_b;
endmodule

`default_nettype wire

// ### verif/test_multimode_timer_capture_block.sv
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// bench
// ---------------------------------------------------------------
module test_multimode_timer_capture_block;
   typedef struct packed {logic [3:0] a; logic [15:0] w; logic [15:0] x;} mtc_row_t;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic src_a = 1'b0;
   logic src_b = 1'b0;
   logic pin_a, pin_b, timer_pin_a_o, timer_pin_a_oe, irq_a, irq_b;
   int failures = 0;
   int checks_done = 0;
   logic [15:0] d, e;
   // unmapped index 7 must read back zero
   mtc_row_t rows [5] = '{
      '{mtc_pkg::ADDR_RELOAD_A, 16'h1234, 16'h1234},
      '{mtc_pkg::ADDR_RELOAD_B, 16'hABCD, 16'hABCD},
      '{mtc_pkg::ADDR_COUNT, 16'h0042, 16'h0042},
      '{4'h7, 16'h5555, 16'h0000},
      '{mtc_pkg::ADDR_CTRL, 16'hFF05, 16'h0005}
   };
   logic [15:0] pw [3] = '{16'h0004, 16'h0002, 16'h0004};
   logic [7:0] cm [4] = '{8'h40, 8'hC0, 8'h60, 8'hE0};

   always #5 sys_clk = ~sys_clk;

   mtc_timer DUT (
      .sys_clk(sys_clk),
      .reset(reset),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .timer_pin_a_i(pin_a),
      .timer_pin_a_o(timer_pin_a_o),
      .timer_pin_a_oe(timer_pin_a_oe),
      .timer_pin_b(pin_b),
      .irq_a(irq_a),
      .irq_b(irq_b)
   );

   mtc_pins pins (
      .src_a(src_a),
      .src_b(src_b),
      .pin_a_o(timer_pin_a_o),
      .pin_a_oe(timer_pin_a_oe),
      .pin_a(pin_a),
      .pin_b(pin_b)
   );

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] w);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= w;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] r);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 r = reg_rdata;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      checks_done++;
      if (g !== x) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask

   task automatic chkb(input logic g, input logic x);
      checks_done++;
      if (g !== x) begin
         failures++;
         $display("wrong value at %0t: flag %b expected %b", $time, g, x);
      end
   endtask

   task automatic rchk(input logic [3:0] a, input logic [15:0] x);
      rd(a, d);
      chk(d, x);
   endtask

   task automatic pulse(input logic [1:0] m);
      @(posedge sys_clk);
      {src_b, src_a} <= m;
      cyc(2);
      {src_b, src_a} <= 2'b00;
      cyc(2);
   endtask

   // cycles until the pwm pin changes; bounded so a dead output ends the run
   task automatic gap(output int n);
      logic v;
      v = timer_pin_a_o;
      n = 0;
      while (timer_pin_a_o === v && n < 40) begin
         @(posedge sys_clk);
         #1 n++;
      end
      if (n >= 40) begin
         failures++;
         summarize();
      end
   endtask

   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      int n;
      logic [15:0] ra, rb;
      logic pa, pb;
      cyc(6);
      reset <= 1'b0;
      rchk(mtc_pkg::ADDR_CTRL, 16'h0000);
      chkb(irq_a, 1'b0);
      chkb(timer_pin_a_oe, 1'b0);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rchk(rows[i].a, rows[i].x);
      end
      // event counting, stopped first, then run in the 001 encoding
      wr(mtc_pkg::ADDR_COUNT, 16'h0002);
      wr(mtc_pkg::ADDR_RELOAD_A, 16'h0005);
      pulse(2'b01);
      rchk(mtc_pkg::ADDR_COUNT, 16'h0002);
      wr(mtc_pkg::ADDR_CTRL, 16'h0035);
      repeat (3) pulse(2'b01);
      rchk(mtc_pkg::ADDR_COUNT, 16'h0005);
      rchk(mtc_pkg::ADDR_CTRL, 16'h003D);
      chkb(irq_a, 1'b1);
      chkb(timer_pin_a_oe, 1'b0);
      pulse(2'b10);
      rchk(mtc_pkg::ADDR_CTRL, 16'h003F);
      chkb(irq_b, 1'b1);
      wr(mtc_pkg::ADDR_CTRL, 16'h0030);
      chkb(irq_a, 1'b0);
      pulse(2'b10);
      rchk(mtc_pkg::ADDR_CTRL, 16'h0030);
      // pwm with toggling: on time A+1, off time B+1, A first
      wr(mtc_pkg::ADDR_RELOAD_A, 16'h0003);
      wr(mtc_pkg::ADDR_RELOAD_B, 16'h0001);
      wr(mtc_pkg::ADDR_COUNT, 16'h0000);
      wr(mtc_pkg::ADDR_CTRL, 16'h00B5);
      chkb(timer_pin_a_oe, 1'b1);
      gap(n);
      foreach (pw[i]) begin
         gap(n);
         chk(16'(n), pw[i]);
      end
      rchk(mtc_pkg::ADDR_CTRL, 16'h00BF);
      chkb(irq_b, 1'b1);
      wr(mtc_pkg::ADDR_CTRL, 16'h0090);
      chkb(timer_pin_a_oe, 1'b0);
      // capture underflow shares interrupt A
      wr(mtc_pkg::ADDR_CTRL, 16'h0000);
      wr(mtc_pkg::ADDR_COUNT, 16'h0008);
      wr(mtc_pkg::ADDR_CTRL, 16'h0044);
      cyc(12);
      rchk(mtc_pkg::ADDR_CTRL, 16'h0054);
      chkb(irq_a, 1'b1);
      // underflow flag left up, enable A off: the gate alone must hold irq low
      wr(mtc_pkg::ADDR_CTRL, 16'h0050);
      chkb(irq_a, 1'b0);
      // every capture encoding: selected edges 5 cycles apart
      foreach (cm[i]) begin
         pa = cm[i][5];
         pb = cm[i][7] | cm[i][5];
         wr(mtc_pkg::ADDR_CTRL, 16'h0000);
         @(posedge sys_clk);
         {src_b, src_a} <= {pb, pa};
         wr(mtc_pkg::ADDR_COUNT, 16'h8000);
         wr(mtc_pkg::ADDR_CTRL, {8'h00, cm[i]} | 16'h0005);
         @(posedge sys_clk);
         src_a <= ~pa;
         cyc(5);
         src_b <= ~pb;
         cyc(3);
         rd(mtc_pkg::ADDR_RELOAD_A, ra);
         rd(mtc_pkg::ADDR_RELOAD_B, rb);
         chk(ra - rb, 16'h0005);
         rchk(mtc_pkg::ADDR_CTRL, {8'h00, cm[i]} | 16'h000F);
         chkb(irq_b, 1'b1);
         rd(mtc_pkg::ADDR_COUNT, d);
         rd(mtc_pkg::ADDR_COUNT, e);
         chk(d - e, 16'h0002);
         @(posedge sys_clk);
         {src_b, src_a} <= {pb, pa};
         cyc(3);
         rchk(mtc_pkg::ADDR_RELOAD_A, ra);
      end
      // mid-run reset with pins left high: all state back to zero
      @(posedge sys_clk);
      reset <= 1'b1;
      cyc(2);
      reset <= 1'b0;
      rchk(mtc_pkg::ADDR_CTRL, 16'h0000);
      rchk(mtc_pkg::ADDR_RELOAD_A, 16'h0000);
      rchk(mtc_pkg::ADDR_COUNT, 16'h0000);
      chkb(irq_b, 1'b0);
      summarize();
   end
endmodule

`default_nettype wire
